// ### inc/rcsd_regs.vh
`ifndef RCSD_REGS_VH
`define RCSD_REGS_VH
// Opcodes (arbitrary but distinct encodings)
`define RCSD_OP_NOP        8'h00
`define RCSD_OP_BUF_LOAD   8'h02
`define RCSD_OP_BUF_EXEC   8'h03
`define RCSD_OP_CCA_SAMPLE 8'h04
`define RCSD_OP_OSC_ON     8'h40
`define RCSD_OP_TX_CAL     8'h41
`define RCSD_OP_RX_ON      8'h42
`define RCSD_OP_TX_ON      8'h43
`define RCSD_OP_TX_CCA     8'h44
`define RCSD_OP_RF_OFF     8'h45
// Radio states
`define RCSD_RF_IDLE 2'h0
`define RCSD_RF_RX   2'h1
`define RCSD_RF_TX   2'h2
`define RCSD_RF_CAL  2'h3
// Status byte bit positions
`define RCSD_ST_OSC  7
`define RCSD_ST_CCA  6
`define RCSD_ST_TX   5
`define RCSD_ST_RX   4
`define RCSD_ST_CALD 3
`define RCSD_ST_FLT  2
// Fault bit positions
`define RCSD_F_USAGE   0
`define RCSD_F_OPERAND 1
`define RCSD_F_ABORT   2
`define RCSD_F_SPI     3
// Reset and timing values
`define RCSD_OSC_RESET 1'b1
`define RCSD_LAST_BIT 3'h7
`endif

// ### src/rcsd_decoder.v
`timescale 1ns/1ps
`include "rcsd_regs.vh"
module rcsd_decoder (
    input wire ref_clk, // 100 MHz clock
    input wire rst_n, // Async reset, active low
    input wire sclk, // Serial clock from host
    input wire chip_select_low, // Chip select, active low
    input wire mosi, // Serial data in
    output reg miso, // Serial data out (status)
    input wire cca_in, // Clear channel indication
    input wire rx_frame_active, // Frame being received
    input wire [3:0] fault_clear, // Fault clear pulses, one per fault
    output reg crystal_oscillator, // Oscillator enable
    output reg [1:0] rf_state, // Radio state
    output reg synth_calibrated, // Synthesizer calibrated
    output reg [3:0] fault_flags, // Sticky fault flags
    output reg [7:0] status_byte // Current status byte
);
    reg [1:0] sclk_s_reg;
    reg [1:0] cs_s_reg;
    reg [1:0] mosi_s_reg;
    reg [1:0] cca_s_reg;
    reg [1:0] rxf_s_reg;
    reg sclk_d_reg;
    reg cs_d_reg;
    reg [7:0] shift_reg;
    reg [2:0] bit_cnt_reg;
    reg first_byte_reg;
    reg param_pend_reg;
    reg halted_reg;
    reg cca_lat_reg;
    reg [7:0] ibuf_reg;
    reg [7:0] tx_shift_reg;
    reg [3:0] flt_set;
    reg [1:0] rf_next;
    reg osc_next;
    reg cal_next;
    reg cca_next;
    reg [7:0] ibuf_next;
    reg halt_set;
    reg pend_next;
    reg [7:0] op;
    reg [7:0] byte_in;
    wire sclk_rise;
    wire sclk_fall;
    wire cs_active;
    wire cs_rise;
    wire cs_fall;
    wire byte_done;
    reg [7:0] status_now;

    assign cs_active = ~cs_s_reg[1];
    assign sclk_rise = cs_active & sclk_s_reg[1] & ~sclk_d_reg;
    assign sclk_fall = cs_active & ~sclk_s_reg[1] & sclk_d_reg;
    assign cs_rise = cs_s_reg[1] & ~cs_d_reg;
    assign cs_fall = ~cs_s_reg[1] & cs_d_reg;
    assign byte_done = sclk_rise & (bit_cnt_reg == `RCSD_LAST_BIT) & ~halted_reg;

    // Status byte assembled from live state
    always @* begin
        status_now = 8'h00;
        status_now[`RCSD_ST_OSC] = crystal_oscillator;
        status_now[`RCSD_ST_CCA] = cca_lat_reg;
        status_now[`RCSD_ST_TX] = (rf_state == `RCSD_RF_TX);
        status_now[`RCSD_ST_RX] = (rf_state == `RCSD_RF_RX);
        status_now[`RCSD_ST_CALD] = synth_calibrated;
        status_now[`RCSD_ST_FLT] = |fault_flags;
    end

    function allowed_in_buf;
        input [7:0] code;
        begin
            allowed_in_buf = (code == `RCSD_OP_NOP) || (code == `RCSD_OP_CCA_SAMPLE) ||
                (code == `RCSD_OP_TX_CAL) || (code == `RCSD_OP_RX_ON) ||
                (code == `RCSD_OP_TX_ON) || (code == `RCSD_OP_TX_CCA) ||
                (code == `RCSD_OP_RF_OFF);
        end
    endfunction

    // Instruction decode on a completed byte
    always @* begin
        byte_in = {shift_reg[6:0], mosi_s_reg[1]};
        flt_set = 4'h0;
        rf_next = rf_state;
        osc_next = crystal_oscillator;
        cal_next = synth_calibrated;
        cca_next = cca_lat_reg;
        ibuf_next = ibuf_reg;
        halt_set = 1'b0;
        pend_next = param_pend_reg;
        op = byte_in;
        if (cs_rise && (bit_cnt_reg != 3'h0)) begin
            flt_set[`RCSD_F_SPI] = 1'b1;
        end
        if (cs_rise && param_pend_reg) begin
            flt_set[`RCSD_F_OPERAND] = 1'b1;
            pend_next = 1'b0;
        end
        if (byte_done) begin
            if (param_pend_reg) begin
                ibuf_next = byte_in;
                pend_next = 1'b0;
                op = `RCSD_OP_NOP;
            end else if (byte_in == `RCSD_OP_BUF_EXEC) begin
                op = ibuf_reg;
                ibuf_next = `RCSD_OP_NOP;
                if (!allowed_in_buf(ibuf_reg)) begin
                    flt_set[`RCSD_F_USAGE] = 1'b1;
                    op = `RCSD_OP_NOP;
                end
            end
            // Buffered code runs through the same path; codes barred from the buffer raise a usage fault
            case (op)
                `RCSD_OP_NOP: begin
                    rf_next = rf_state;
                end
                `RCSD_OP_BUF_LOAD: begin
                    if (!param_pend_reg) begin
                        pend_next = 1'b1;
                    end
                end
                `RCSD_OP_CCA_SAMPLE: begin
                    cca_next = cca_s_reg[1];
                end
                `RCSD_OP_OSC_ON: begin
                    if (!first_byte_reg) begin
                        flt_set[`RCSD_F_OPERAND] = 1'b1;
                        halt_set = 1'b1;
                    end else begin
                        osc_next = 1'b1;
                    end
                end
                `RCSD_OP_TX_CAL: begin
                    flt_set[`RCSD_F_ABORT] = rxf_s_reg[1];
                    rf_next = `RCSD_RF_CAL;
                    cal_next = 1'b1;
                end
                `RCSD_OP_RX_ON: begin
                    flt_set[`RCSD_F_ABORT] = rxf_s_reg[1];
                    rf_next = `RCSD_RF_RX;
                end
                `RCSD_OP_TX_ON: begin
                    flt_set[`RCSD_F_ABORT] = rxf_s_reg[1];
                    rf_next = `RCSD_RF_TX;
                    cal_next = 1'b1;
                end
                `RCSD_OP_TX_CCA: begin
                    cca_next = cca_s_reg[1];
                    if (cca_s_reg[1]) begin
                        rf_next = `RCSD_RF_TX;
                        cal_next = 1'b1;
                    end
                end
                `RCSD_OP_RF_OFF: begin
                    if (rf_state == `RCSD_RF_IDLE) begin
                        flt_set[`RCSD_F_USAGE] = 1'b1;
                    end else begin
                        flt_set[`RCSD_F_ABORT] = rxf_s_reg[1];
                        rf_next = `RCSD_RF_IDLE;
                        cal_next = 1'b0;
                    end
                end
                default: begin
                    flt_set[`RCSD_F_OPERAND] = 1'b1;
                    halt_set = 1'b1;
                end
            endcase
        end
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_s_reg <= 2'h0;
            cs_s_reg <= 2'h3;
            mosi_s_reg <= 2'h0;
            cca_s_reg <= 2'h0;
            rxf_s_reg <= 2'h0;
            sclk_d_reg <= 1'b0;
            cs_d_reg <= 1'b1;
        end else begin
            sclk_s_reg <= {sclk_s_reg[0], sclk};
            cs_s_reg <= {cs_s_reg[0], chip_select_low};
            mosi_s_reg <= {mosi_s_reg[0], mosi};
            cca_s_reg <= {cca_s_reg[0], cca_in};
            rxf_s_reg <= {rxf_s_reg[0], rx_frame_active};
            sclk_d_reg <= sclk_s_reg[1];
            cs_d_reg <= cs_s_reg[1];
        end
    end

    // Bit counter restarts whenever the frame is deselected
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt_reg <= 3'h0;
        end else if (!cs_active) begin
            bit_cnt_reg <= 3'h0;
        end else if (sclk_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
        end
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_reg <= 8'h00;
        end else if (sclk_rise) begin
            shift_reg <= byte_in;
        end
    end

    // Only the opening byte of a frame may start the oscillator
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            first_byte_reg <= 1'b1;
        end else if (!cs_active) begin
            first_byte_reg <= 1'b1;
        end else if (byte_done) begin
            first_byte_reg <= 1'b0;
        end
    end

    // Aborted frame ignores further bytes until reselected
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            halted_reg <= 1'b0;
        end else if (halt_set) begin
            halted_reg <= 1'b1;
        end else if (!cs_active) begin
            halted_reg <= 1'b0;
        end
    end

    // Parameter byte owed by a buffer load
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            param_pend_reg <= 1'b0;
        end else begin
            param_pend_reg <= pend_next;
        end
    end

    // Single-entry instruction buffer
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ibuf_reg <= `RCSD_OP_NOP;
        end else begin
            ibuf_reg <= ibuf_next;
        end
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cca_lat_reg <= 1'b0;
        end else begin
            cca_lat_reg <= cca_next;
        end
    end

    // Pin reset starts the oscillator
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            crystal_oscillator <= `RCSD_OSC_RESET;
        end else begin
            crystal_oscillator <= osc_next;
        end
    end

    // Radio state register
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rf_state <= `RCSD_RF_IDLE;
        end else begin
            rf_state <= rf_next;
        end
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            synth_calibrated <= 1'b0;
        end else begin
            synth_calibrated <= cal_next;
        end
    end

    // Set wins over clear
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_flags <= 4'h0;
        end else begin
            fault_flags <= (fault_flags & ~fault_clear) | flt_set;
        end
    end

    // Registered copy for the status port
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_byte <= 8'h00;
        end else begin
            status_byte <= status_now;
        end
    end

    // Status reloads at frame start and at every byte boundary
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_shift_reg <= 8'h00;
        end else if (cs_fall || (sclk_fall && bit_cnt_reg == 3'h0)) begin
            tx_shift_reg <= {status_now[6:0], 1'b0};
        end else if (sclk_fall) begin
            tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
        end
    end

    // Data out changes on the falling serial edge, MSB first
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            miso <= 1'b0;
        end else if (cs_fall || (sclk_fall && bit_cnt_reg == 3'h0)) begin
            miso <= status_now[7];
        end else if (sclk_fall) begin
            miso <= tx_shift_reg[7];
        end
    end
endmodule // rcsd_decoder

// ### sim/rcsd_checker.sv
`timescale 1ns/1ps
module rcsd_checker (
    input wire ref_clk, // Clock
    input wire rst_n, // Reset
    input wire chip_select_low, // Select
    input wire rx_frame_active, // Frame busy
    input wire [3:0] fault_clear, // Clears
    input wire crystal_oscillator, // Osc on
    input wire [1:0] rf_state, // Radio
    input wire synth_calibrated, // Calibrated
    input wire [3:0] fault_flags, // Faults
    input wire [7:0] status_byte // Status
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    AST_STICKY: assert property (
        (~fault_flags & $past(fault_flags & ~fault_clear)) == 4'h0) else $error("fault lost");
    AST_FLT_SHOWN: assert property ($rose(|fault_flags) |-> ##[0:2] status_byte[2])
        else $error("fault not in status");
    AST_OSC_SHOWN: assert property (crystal_oscillator |-> ##[0:2] status_byte[7])
        else $error("osc not in status");
    AST_QUIET: assert property (chip_select_low [*8] |=>
        $stable({rf_state, crystal_oscillator, synth_calibrated})) else $error("idle change");
    AST_OFF_UNCAL: assert property ($changed(rf_state) && rf_state == 2'h0 |->
        ##[0:1] !synth_calibrated) else $error("idle but calibrated");
    AST_TX_CAL: assert property ($changed(rf_state) && rf_state == 2'h2 |->
        ##[0:1] synth_calibrated) else $error("tx uncalibrated");
    AST_WAIT_CAL: assert property ($changed(rf_state) && rf_state == 2'h3 |->
        ##[0:1] synth_calibrated) else $error("wait uncalibrated");
    AST_ABORT: assert property ($rose(fault_flags[2]) |-> rx_frame_active)
        else $error("abort without frame");
endmodule // rcsd_checker
bind rcsd_decoder rcsd_checker chk_u (.ref_clk, .rst_n, .chip_select_low, .rx_frame_active,
    .fault_clear, .crystal_oscillator, .rf_state, .synth_calibrated, .fault_flags, .status_byte);

// ### sim/rcsd_host.sv
`timescale 1ns/1ps
module rcsd_host (
    input wire ref_clk, // Bench clock
    output reg sclk, // Serial clock
    output reg chip_select_low, // Frame select
    output reg mosi, // Serial data
    input wire miso // Status data
);
    reg [15:0] rx_word;
    initial begin
        sclk = 1'b0;
        chip_select_low = 1'b1;
        mosi = 1'b0;
    end
    task half; // Half of a 160 ns period
        repeat (8) @(negedge ref_clk);
    endtask
    task frame(input [15:0] w, input integer n);
        integer i;
        chip_select_low = 1'b0;
        for (i = 15; i > 15 - n; i = i - 1) begin
            mosi = w[i];
            half;
            sclk = 1'b1;
            rx_word = {rx_word[14:0], miso};
            half;
            sclk = 1'b0;
        end
        half;
        chip_select_low = 1'b1;
        mosi = ~mosi;
        half;
    endtask
endmodule // rcsd_host

// ### sim/radio_command_strobe_decoder_bench.sv
`timescale 1ns/1ps
`include "rcsd_regs.vh"
module radio_command_strobe_decoder_bench;
    reg ref_clk, rst_n, cca_in, rx_frame_active;
    reg [3:0] fault_clear;
    wire sclk, chip_select_low, mosi, miso, crystal_oscillator, synth_calibrated;
    wire [1:0] rf_state;
    wire [3:0] fault_flags;
    wire [7:0] status_byte;
    integer n_mismatch = 0, n_compared = 0, cycles = 0;
    rcsd_host host_u (.ref_clk, .sclk, .chip_select_low, .mosi, .miso);
    rcsd_decoder dut_u (.ref_clk, .rst_n, .sclk, .chip_select_low, .mosi, .miso, .cca_in,
        .rx_frame_active, .fault_clear, .crystal_oscillator, .rf_state, .synth_calibrated,
        .fault_flags, .status_byte);
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task chk(input string nm, input [7:0] exp, input [7:0] got);
        n_compared = n_compared + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("wrong value %0s expected %h seen %h", nm, exp, got);
        end
    endtask
    task cmd(input [7:0] op);
        host_u.frame({op, 8'h00}, 8);
    endtask
    task clr;
        fault_clear = 4'hf;
        @(negedge ref_clk);
        fault_clear = 4'h0;
        @(negedge ref_clk);
    endtask
    task flt(input [3:0] e);
        chk("faults", {4'h0, e}, {4'h0, fault_flags});
        clr;
    endtask
    task rf(input [1:0] e);
        chk("state", {6'h0, e}, {6'h0, rf_state});
    endtask
    task t_idle;
        cmd(`RCSD_OP_NOP);
        chk("status", 8'h80, host_u.rx_word[7:0]);
        flt(4'h0);
        cmd(`RCSD_OP_RF_OFF);
        flt(4'h1);
        flt(4'h0);
    endtask
    task t_osc;
        host_u.frame({`RCSD_OP_OSC_ON, `RCSD_OP_NOP}, 16);
        chk("osc", 8'h01, {7'h0, crystal_oscillator});
        flt(4'h0);
        host_u.frame({`RCSD_OP_NOP, `RCSD_OP_OSC_ON}, 16);
        flt(4'h2);
    endtask
    task t_radio;
        cca_in = 1'b1;
        cmd(`RCSD_OP_CCA_SAMPLE);
        chk("cca", 8'h01, {7'h0, status_byte[6]});
        rf(`RCSD_RF_IDLE);
        cca_in = 1'b0;
        cmd(`RCSD_OP_TX_CCA);
        chk("cca", 8'h00, {7'h0, status_byte[6]});
        rf(`RCSD_RF_IDLE);
        cca_in = 1'b1;
        cmd(`RCSD_OP_TX_CCA);
        rf(`RCSD_RF_TX);
        chk("cal", 8'h01, {7'h0, synth_calibrated});
        chk("status", 8'he8, status_byte);
        cmd(`RCSD_OP_RF_OFF);
        rf(`RCSD_RF_IDLE);
        cmd(`RCSD_OP_TX_CAL);
        rf(`RCSD_RF_CAL);
        cmd(`RCSD_OP_TX_ON);
        rf(`RCSD_RF_TX);
        cmd(`RCSD_OP_RF_OFF);
        flt(4'h0);
    endtask
    task t_abort;
        integer i;
        rx_frame_active = 1'b1;
        for (i = 0; i < 4; i = i + 1) begin
            cmd(i == 3 ? `RCSD_OP_RF_OFF : `RCSD_OP_TX_CAL + i[7:0]);
            chk("abort", 8'h01, {7'h0, fault_flags[2]});
            clr;
        end
        cmd(`RCSD_OP_TX_CCA);
        chk("abort", 8'h00, {7'h0, fault_flags[2]});
        rx_frame_active = 1'b0;
        cmd(`RCSD_OP_RF_OFF);
        clr;
    endtask
    task t_buf;
        host_u.frame({`RCSD_OP_BUF_LOAD, `RCSD_OP_RX_ON}, 16);
        rf(`RCSD_RF_IDLE);
        cmd(`RCSD_OP_BUF_EXEC);
        rf(`RCSD_RF_RX);
        cmd(`RCSD_OP_TX_ON);
        chk("status", 8'hd0, host_u.rx_word[7:0]);
        cmd(`RCSD_OP_BUF_EXEC);
        rf(`RCSD_RF_TX);
        cmd(`RCSD_OP_RF_OFF);
        flt(4'h0);
        host_u.frame({`RCSD_OP_BUF_LOAD, `RCSD_OP_OSC_ON}, 16);
        cmd(`RCSD_OP_BUF_EXEC);
        flt(4'h1);
        host_u.frame({`RCSD_OP_BUF_LOAD, `RCSD_OP_RF_OFF}, 16);
        cmd(`RCSD_OP_BUF_EXEC);
        flt(4'h1);
    endtask
    task t_err;
        cmd(8'h7e);
        flt(4'h2);
        cmd(`RCSD_OP_BUF_LOAD);
        flt(4'h2);
        host_u.frame({`RCSD_OP_NOP, 8'h00}, 4);
        flt(4'h8);
    endtask
    task final_report;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            n_mismatch = n_mismatch + 1;
            final_report;
        end
    end
    initial begin
        rst_n = 1'b0;
        cca_in = 1'b0;
        rx_frame_active = 1'b0;
        fault_clear = 4'h0;
        repeat (20) @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge ref_clk);
        t_idle;
        t_osc;
        t_radio;
        t_abort;
        t_buf;
        t_err;
        final_report;
    end
endmodule // radio_command_strobe_decoder_bench
